// ===== rtl/cti_filter.sv
// Identifier acceptance filter with hit index
`timescale 1ns/1ns
`default_nettype none
module cti_filter
  import cti_pkg::*;
(
  input  wire logic [1:0]  mode_i,
  input  wire logic        extended_i,
  input  wire logic [31:0] id_i,
  input  wire logic [31:0] code_i,
  input  wire logic [31:0] mask_i,
  output logic             accept_o,
  output logic [1:0]       hit_o
);

  logic [31:0] bit_ok;
  logic [3:0]  byte_ok;
  logic [3:0]  used;
  logic [3:0]  byte_pass;
  logic [3:0]  filt_hit;

  // Mask one means don't-care; byte 0 is the first identifier byte
  assign bit_ok = ~(id_i ^ code_i) | mask_i;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_byte
      assign byte_ok[g] = &bit_ok[g*8 +: 8];
      assign used[g]    = extended_i || (g <= STD_IDX_LAST);
      assign byte_pass[g] = byte_ok[g] || !used[g];
    end
  endgenerate

  always_comb begin
    filt_hit = 4'h0;
    unique case (cti_mode_t'(mode_i))
      MODE_ONE32:  filt_hit[0] = &byte_pass;
      // Standard identifiers leave bytes 2-3 unused, so filter 1 never hits
      MODE_TWO16:  filt_hit = {2'h0, &byte_ok[3:2] & used[2],
                               &byte_pass[1:0]};
      MODE_FOUR8:  filt_hit = byte_pass & used;
      MODE_CLOSED: filt_hit = 4'h0;
    endcase
  end

  assign accept_o = |filt_hit;
  // Lowest matching filter wins
  assign hit_o = filt_hit[0] ? 2'h0 : filt_hit[1] ? 2'h1 :
                 filt_hit[2] ? 2'h2 : 2'h3;

endmodule
`default_nettype wire

// ===== rtl/cti_pkg.sv
// Package of constants and types for the transmit-abort and identifier filter
package cti_pkg;

  // ---------------------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_TXFLG  = 8'h00;
  localparam logic [7:0] ADDR_TXCTL  = 8'h04;
  localparam logic [7:0] ADDR_ACCCTL = 8'h08;
  localparam logic [7:0] ADDR_RXERR  = 8'h0c;
  localparam logic [7:0] ADDR_TXERR  = 8'h10;
  localparam logic [7:0] ADDR_MODCTL = 8'h14;
  localparam logic [7:0] ADDR_CODE0  = 8'h20;
  localparam logic [7:0] ADDR_MASK0  = 8'h30;

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int         NUM_BUF      = 3;
  localparam int         ABT_LSB      = 4;
  localparam int         IE_LSB       = 0;
  localparam int         HIT_LSB      = 0;
  localparam int         MODE_LSB     = 4;
  localparam int         SOFT_RESET_CONTROL_BIT_BIT   = 0;
  localparam logic [2:0] TXE_RESET    = 3'h7;
  localparam logic [7:0] FILT_RESET   = 8'h00;
  localparam logic [1:0] STD_IDX_LAST = 2'h1;

  typedef enum logic [1:0] {
    MODE_ONE32  = 2'h0,
    MODE_TWO16  = 2'h1,
    MODE_FOUR8  = 2'h2,
    MODE_CLOSED = 2'h3
  } cti_mode_t;

  // Per-buffer transmit engine report
  typedef struct packed {
    logic [2:0] sent;
    logic [2:0] started;
    logic [2:0] failed;
  } cti_tx_evt_t;

  // Received identifier with format
  typedef struct packed {
    logic        valid;
    logic        extended;
    logic [31:0] id;
  } cti_rx_id_t;

endpackage

// ===== rtl/cti_top.sv
// Transmit flags, abort handshake, acceptance filter and APB register file
`timescale 1ns/1ns
`default_nettype none
module cti_top
  import cti_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire cti_tx_evt_t tx_evt_i,
  input  wire cti_rx_id_t  rx_id_i,
  input  wire logic [7:0]  rx_err_cnt_i,
  input  wire logic [7:0]  tx_err_cnt_i,
  output logic [2:0]       tx_pending_o,
  output logic [2:0]       abort_grant_o,
  output logic             txe_irq_o,
  output logic             rx_accept_o,
  output logic [1:0]       hit_o,
  output logic             soft_reset_o
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [2:0]  txe_q, txe_d;
  logic [2:0]  ack_q, ack_d;
  logic [2:0]  abt_q, abt_d;
  logic [2:0]  ie_q, ie_d;
  logic [2:0]  busy_q, busy_d;
  logic        sft_q;
  logic [1:0]  mode_q;
  logic [1:0]  hit_q;
  logic [31:0] code_q;
  logic [31:0] mask_q;
  logic        fg_full_q;
  logic        accept_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        irq_q;
  logic [2:0]  grant_q;

  // ---------------------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------------------
  logic        acc_cyc;
  logic        wr_cyc;
  logic        wr_flg;
  logic        wr_ctl;
  logic        wr_acc;
  logic        wr_mod;
  logic        wr_code;
  logic        wr_mask;
  logic        mapped;
  logic [1:0]  bidx;
  logic [7:0]  wb;

  function automatic logic hit_addr(input logic [7:0] a,
                                    input logic [7:0] base);
    hit_addr = (a == base);
  endfunction

  function automatic logic hit_bank(input logic [7:0] a,
                                    input logic [7:0] base);
    hit_bank = (a[7:4] == base[7:4]) && (a[1:0] == 2'h0);
  endfunction

  // Two-cycle access phase: pready rises one cycle after penable
  assign acc_cyc = psel_i && penable_i && !pready_q;
  assign wr_cyc  = acc_cyc && pwrite_i && pstrb_i[0];
  assign wr_flg  = wr_cyc && hit_addr(paddr_i, ADDR_TXFLG);
  assign wr_ctl  = wr_cyc && hit_addr(paddr_i, ADDR_TXCTL);
  assign wr_mod  = wr_cyc && hit_addr(paddr_i, ADDR_MODCTL);
  // Filter setup only under soft reset
  assign wr_acc  = wr_cyc && sft_q && hit_addr(paddr_i, ADDR_ACCCTL);
  assign wr_code = wr_cyc && sft_q && hit_bank(paddr_i, ADDR_CODE0);
  assign wr_mask = wr_cyc && sft_q && hit_bank(paddr_i, ADDR_MASK0);
  assign bidx    = paddr_i[3:2];
  assign wb      = pwdata_i[7:0];
  assign mapped  = hit_addr(paddr_i, ADDR_TXFLG) ||
                   hit_addr(paddr_i, ADDR_TXCTL) ||
                   hit_addr(paddr_i, ADDR_ACCCTL) ||
                   hit_addr(paddr_i, ADDR_RXERR) ||
                   hit_addr(paddr_i, ADDR_TXERR) ||
                   hit_addr(paddr_i, ADDR_MODCTL) ||
                   hit_bank(paddr_i, ADDR_CODE0) ||
                   hit_bank(paddr_i, ADDR_MASK0);

  // ---------------------------------------------------------------------------
  // Transmit handshake
  // ---------------------------------------------------------------------------
  logic [2:0] sw_clr;
  logic [2:0] sw_abt;
  logic [2:0] grant;
  logic [2:0] set_txe;

  assign sw_clr = wr_flg ? wb[2:0] : 3'h0;
  // Zero bits are ignored: software can only raise a request
  assign sw_abt = wr_ctl ? wb[ABT_LSB +: NUM_BUF] : 3'h0;
  // Abort only when idle-scheduled or after a failed attempt
  assign grant = abt_q & ~txe_q & (~busy_q | tx_evt_i.failed)
                 & ~tx_evt_i.sent;
  assign set_txe = (tx_evt_i.sent & ~txe_q) | grant;

  always_comb begin
    // Hardware set wins over a software clear in the same cycle
    txe_d  = (txe_q & ~sw_clr) | set_txe;
    // Clearing empty drops the acknowledge of the previous message
    ack_d  = (ack_q & ~sw_clr) | grant;
    abt_d  = (abt_q | sw_abt) & ~set_txe;
    ie_d   = wr_ctl ? wb[IE_LSB +: NUM_BUF] : ie_q;
    busy_d = (busy_q | tx_evt_i.started) &
             ~(tx_evt_i.failed | tx_evt_i.sent | txe_q);
    if (sft_q) begin
      txe_d  = TXE_RESET;
      ack_d  = 3'h0;
      abt_d  = 3'h0;
      ie_d   = 3'h0;
      busy_d = 3'h0;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      txe_q  <= TXE_RESET;
      ack_q  <= 3'h0;
      abt_q  <= 3'h0;
      ie_q   <= 3'h0;
      busy_q <= 3'h0;
    end else begin
      txe_q  <= txe_d;
      ack_q  <= ack_d;
      abt_q  <= abt_d;
      ie_q   <= ie_d;
      busy_q <= busy_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Module control and filter registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sft_q <= 1'b1;
    end else if (wr_mod) begin
      sft_q <= wb[SOFT_RESET_CONTROL_BIT_BIT];
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_q <= 2'h0;
      code_q <= {4{FILT_RESET}};
      mask_q <= {4{FILT_RESET}};
    end else begin
      if (wr_acc) begin
        mode_q <= wb[MODE_LSB +: 2];
      end
      if (wr_code) begin
        code_q[bidx*8 +: 8] <= wb;
      end
      if (wr_mask) begin
        mask_q[bidx*8 +: 8] <= wb;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Acceptance and foreground reload
  // ---------------------------------------------------------------------------
  logic       flt_accept;
  logic [1:0] flt_hit;
  logic       reload;

  cti_filter u_filter (
    .mode_i     (mode_q),
    .extended_i (rx_id_i.extended),
    .id_i       (rx_id_i.id),
    .code_i     (code_q),
    .mask_i     (mask_q),
    .accept_o   (flt_accept),
    .hit_o      (flt_hit)
  );

  // Rejected frames stay in background and get overwritten by the next
  assign reload = rx_id_i.valid && flt_accept && !sft_q;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hit_q     <= 2'h0;
      fg_full_q <= 1'b0;
      accept_q  <= 1'b0;
    end else begin
      accept_q  <= reload;
      fg_full_q <= fg_full_q | reload;
      if (reload) begin
        hit_q <= flt_hit;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Read path and bus answer
  // ---------------------------------------------------------------------------
  logic [7:0] rd_byte;

  assign rd_byte =
    hit_addr(paddr_i, ADDR_TXFLG)  ? {1'b0, ack_q, 1'b0, txe_q} :
    hit_addr(paddr_i, ADDR_TXCTL)  ? {1'b0, abt_q, 1'b0, ie_q} :
    hit_addr(paddr_i, ADDR_ACCCTL) ? {2'h0, mode_q, 2'h0, hit_q} :
    hit_addr(paddr_i, ADDR_RXERR)  ? rx_err_cnt_i :
    hit_addr(paddr_i, ADDR_TXERR)  ? tx_err_cnt_i :
    hit_addr(paddr_i, ADDR_MODCTL) ? {7'h00, sft_q} :
    hit_bank(paddr_i, ADDR_CODE0)  ? code_q[bidx*8 +: 8] :
    hit_bank(paddr_i, ADDR_MASK0)  ? mask_q[bidx*8 +: 8] : 8'h00;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= acc_cyc;
      pslverr_q <= acc_cyc && !mapped;
      if (acc_cyc && !pwrite_i) begin
        prdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_q   <= 1'b0;
      grant_q <= 3'h0;
    end else begin
      irq_q   <= |(txe_d & ie_d);
      grant_q <= grant;
    end
  end

  assign prdata_o      = prdata_q;
  assign pready_o      = pready_q;
  assign pslverr_o     = pslverr_q;
  assign tx_pending_o  = ~txe_q;
  assign abort_grant_o = grant_q;
  assign txe_irq_o     = irq_q;
  assign rx_accept_o   = accept_q;
  assign hit_o         = hit_q;
  assign soft_reset_o  = sft_q;

endmodule
`default_nettype wire

// ===== testbench/cti_can_node.sv
// Bus-side model: transmit engine reports and received identifiers
`timescale 1ns/1ns
`default_nettype none
module cti_can_node
  import cti_pkg::*;
(
  input  wire logic       clock_i,
  output var cti_tx_evt_t tx_evt_o,
  output var cti_rx_id_t  rx_id_o
);
  // ---------------------------------------------------------------
  // Drivers
  // ---------------------------------------------------------------
  initial begin
    tx_evt_o = '0;
    rx_id_o = '0;
  end
  // One-cycle report; callers send started before sent or failed
  task automatic tx(input cti_tx_evt_t e);
    @(posedge clock_i);
    tx_evt_o <= e;
    @(posedge clock_i);
    tx_evt_o <= '0;
  endtask
  // Lines show the inverse after the pulse, never a stale frame
  task automatic frame(input logic x, input logic [31:0] id);
    @(posedge clock_i);
    rx_id_o <= {1'b1, x, id};
    @(posedge clock_i);
    rx_id_o <= {1'b0, ~x, ~id};
  endtask
endmodule
`default_nettype wire

// ===== testbench/cti_top_monitor.sv
// Port-level assertion checker for the transmit and filter block
`timescale 1ns/1ns
`default_nettype none
module cti_top_monitor
  import cti_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        rstn_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0]  pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire cti_tx_evt_t tx_evt_i,
  input wire cti_rx_id_t  rx_id_i,
  input wire logic [7:0]  rx_err_cnt_i,
  input wire logic [7:0]  tx_err_cnt_i,
  input wire logic [2:0]  tx_pending_o,
  input wire logic [2:0]  abort_grant_o,
  input wire logic        txe_irq_o,
  input wire logic        rx_accept_o,
  input wire logic [1:0]  hit_o,
  input wire logic        soft_reset_o
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  sequence access_s; psel_i && penable_i && !pready_o; endsequence
  sequence answer_s; pready_o ##1 !pready_o; endsequence
  apb_answer_a: assert property (access_s |=> answer_s)
    else $error("access not answered in one cycle");
  ready_cause_a: assert property (pready_o |-> $past(psel_i && penable_i))
    else $error("ready without access");
  err_ready_a: assert property (pslverr_o |-> pready_o && prdata_o == 0)
    else $error("error outside ready");
  sent_empty_a: assert property (tx_evt_i.sent != 3'h0 |=>
    (tx_pending_o & $past(tx_evt_i.sent)) == 3'h0)
    else $error("sent buffer still pending");
  grant_empty_a: assert property (abort_grant_o != 3'h0 |->
    (tx_pending_o & abort_grant_o) == 3'h0)
    else $error("granted buffer still pending");
  grant_once_a: assert property (abort_grant_o != 3'h0 |=>
    (abort_grant_o & $past(abort_grant_o)) == 3'h0)
    else $error("abort granted twice");
  accept_cause_a: assert property (rx_accept_o |->
    $past(rx_id_i.valid) && !$past(soft_reset_o))
    else $error("accept without frame");
  hit_hold_a: assert property (!rx_accept_o && !soft_reset_o |->
    $stable(hit_o))
    else $error("hit moved without accept");
  soft_hold_a: assert property (soft_reset_o && $past(soft_reset_o) |->
    tx_pending_o == 3'h0 && !txe_irq_o)
    else $error("transmit state not held in soft reset");
  irq_cause_a: assert property (txe_irq_o |-> tx_pending_o != 3'h7)
    else $error("irq with no empty buffer");
endmodule
bind cti_top cti_top_monitor mon_u (.*);
`default_nettype wire

// ===== testbench/cti_top_tb_top.sv
// Self-checking bench of the transmit-abort and filter block
`timescale 1ns/1ns
`default_nettype none
module cti_top_tb_top
  import cti_pkg::*;
;
  logic        clock_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [7:0]  rxc = 8'h00;
  logic [7:0]  txc = 8'h00;
  logic [7:0]  r = 8'h62;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prdata, v, code, mask, id;
  logic [2:0]  pend, grant, e;
  logic [1:0]  hit;
  logic [1:0]  lhit = 2'h0;
  logic        pready, pslverr, irq, acc, srst;
  cti_tx_evt_t ev;
  cti_rx_id_t  rid;
  int          error_cnt = 0;
  int          n_compared = 0;
  logic [32:0] rq[$];
  logic [1:0]  hq[$];
  always #5 clock_i = ~clock_i;
  cti_can_node node_u (.clock_i(clock_i), .tx_evt_o(ev), .rx_id_o(rid));
  cti_top dut_u (
    .clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd), .pstrb_i(4'hf),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .tx_evt_i(ev), .rx_id_i(rid), .rx_err_cnt_i(rxc),
    .tx_err_cnt_i(txc), .tx_pending_o(pend), .abort_grant_o(grant),
    .txe_irq_o(irq), .rx_accept_o(acc), .hit_o(hit), .soft_reset_o(srst));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [32:0] s, ex);
    n_compared++;
    if (s !== ex) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, ex, s);
    end
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic nxt(output logic [31:0] o);
    o = 32'h0;
    repeat (4) begin
      r = {r[6:0], r[7] ^ r[5] ^ r[4] ^ r[3]};
      o = {o[23:0], r};
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clock_i);
    pen <= 1'b1;
    n = 0;
    // Hold the request until pready is sampled high at a rising edge
    do begin
      @(posedge clock_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      error_cnt++;
      test_done();
    end
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] ex);
    rq.push_back(ex);
    apb(1'b0, a, 32'h0);
  endtask
  function automatic logic [2:0] ref_f(input int m, input logic x,
                                       input logic [31:0] i, c, k);
    logic [3:0] t;
    logic [3:0] u;
    for (int b = 0; b < 4; b++)
      t[b] = ((i[8*b+:8] ^ c[8*b+:8]) & ~k[8*b+:8]) == 8'h0;
    u = x ? 4'hf : 4'h3;
    case (m)
      0: return {&(t | ~u), 2'h0};
      1: return {&t[1:0] | (&t[3:2] & x), &t[1:0] ? 2'h0 : 2'h1};
      2: return {|(t & u), t[0] ? 2'h0 : t[1] ? 2'h1 : t[2] ? 2'h2 : 2'h3};
      default: return 3'h0;
    endcase
  endfunction
  // Result watcher: settled outputs are taken at the falling edge
  always @(negedge clock_i) begin
    if (pready === 1'b1 && pwr === 1'b0)
      chk("read", {pslverr, prdata}, rq.pop_front());
    if (acc === 1'b1 && hq.size() == 0)
      chk("accept", 33'h1, 33'h0);
    else if (acc === 1'b1)
      chk("hit", {31'h0, hit}, {31'h0, hq.pop_front()});
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clock_i);
    rstn_i <= 1'b1;
    nxt(v);
    rxc <= v[7:0];
    txc <= v[15:8];
    rd(ADDR_MODCTL, 33'h1);
    rd(ADDR_TXFLG, 33'h7);
    rd(ADDR_RXERR, {25'h0, v[7:0]});
    rd(ADDR_TXERR, {25'h0, v[15:8]});
    rd(8'h40, 33'h1_0000_0000);
    $display("reset test done");
    apb(1'b1, ADDR_MODCTL, 32'h0);
    apb(1'b1, ADDR_TXCTL, 32'h1);
    apb(1'b1, ADDR_TXFLG, 32'h71);
    apb(1'b1, ADDR_TXFLG, 32'h0);
    rd(ADDR_TXFLG, 33'h6);
    chk("irq", {32'h0, irq}, 33'h0);
    node_u.tx(cti_tx_evt_t'(9'h008));
    node_u.tx(cti_tx_evt_t'(9'h040));
    rd(ADDR_TXFLG, 33'h7);
    chk("irq", {32'h0, irq}, 33'h1);
    apb(1'b1, ADDR_TXFLG, 32'h2);
    apb(1'b1, ADDR_TXCTL, 32'h21);
    rd(ADDR_TXFLG, 33'h27);
    apb(1'b1, ADDR_TXFLG, 32'h2);
    rd(ADDR_TXFLG, 33'h5);
    node_u.tx(cti_tx_evt_t'(9'h010));
    apb(1'b1, ADDR_TXCTL, 32'h21);
    apb(1'b1, ADDR_TXCTL, 32'h1);
    rd(ADDR_TXCTL, 33'h21);
    rd(ADDR_TXFLG, 33'h5);
    node_u.tx(cti_tx_evt_t'(9'h002));
    rd(ADDR_TXFLG, 33'h27);
    rd(ADDR_TXCTL, 33'h1);
    apb(1'b1, ADDR_TXCTL, 32'h0);
    chk("irq", {32'h0, irq}, 33'h0);
    apb(1'b1, ADDR_MODCTL, 32'h1);
    rd(ADDR_TXCTL, 33'h0);
    $display("transmit test done");
    for (int m = 0; m < 4; m++) begin
      nxt(code);
      nxt(mask);
      mask = (mask | 32'h700) & 32'hf7f7f7f7;
      apb(1'b1, ADDR_MODCTL, 32'h1);
      for (int b = 0; b < 4; b++) begin
        apb(1'b1, ADDR_CODE0 + 8'(4 * b), {24'h0, code[8*b+:8]});
        apb(1'b1, ADDR_MASK0 + 8'(4 * b), {24'h0, mask[8*b+:8]});
      end
      apb(1'b1, ADDR_ACCCTL, {26'h0, m[1:0], 4'h0});
      apb(1'b1, ADDR_MODCTL, 32'h0);
      apb(1'b1, ADDR_CODE0, ~code);
      apb(1'b1, ADDR_ACCCTL, 32'h0);
      rd(ADDR_CODE0, {25'h0, code[7:0]});
      rd(ADDR_ACCCTL, {27'h0, m[1:0], 2'h0, lhit});
      for (int j = 0; j < 5; j++) begin
        nxt(v);
        id = code ^ (v & mask);
        if (j > 0)
          id = id ^ (32'h8 << (8 * (j - 1)));
        e = ref_f(m, j[0], id, code, mask);
        if (e[2]) begin
          hq.push_back(e[1:0]);
          lhit = e[1:0];
        end
        node_u.frame(j[0], id);
        @(negedge clock_i);
      end
    end
    chk("pending hits", 33'(hq.size()), 33'h0);
    $display("filter test done");
    test_done();
  end
endmodule
`default_nettype wire
